// File: tcpm_defs.svh
// Purpose: Register offsets, field positions, mode encodings and event bits for the port controller.
// Assumes: Registers are one 32-bit word each, addressed by byte offset.
// Notes: Included by the package, by tcpm_top and by the bench.
`ifndef TCPM_DEFS_SVH
`define TCPM_DEFS_SVH

`define TCPM_AW 8
`define TCPM_ADDR_CTRL 8'h00
`define TCPM_ADDR_STATUS 8'h04
`define TCPM_ADDR_FLAGS 8'h08
`define TCPM_ADDR_MASK 8'h0C
`define TCPM_ADDR_IRQ_STAT 8'h10
`define TCPM_ADDR_IRQ_MASK 8'h14
// Control register fields.
`define TCPM_CTRL_TCDIS 0
`define TCPM_CTRL_ACLR 1
`define TCPM_CTRL_SYNCIN 2
`define TCPM_CTRL_CD_LO 4
`define TCPM_CTRL_CD_HI 5
`define TCPM_CTRL_WIDTH 6
// Charge-detect mode encodings.
`define TCPM_CD_SDP 2'b00
`define TCPM_CD_AUTO_CDP 2'b11
// Status register fields.
`define TCPM_ST_CONV 0
`define TCPM_ST_PWM 1
`define TCPM_ST_ORIENT 2
`define TCPM_ST_ATT 3
`define TCPM_ST_SYNCOE 4
// Block event bits: fault flag set, attach, detach.
`define TCPM_EV_FLAG 0
`define TCPM_EV_ATTACH 1
`define TCPM_EV_DETACH 2
`define TCPM_EV_N 3
`define TCPM_NFAULT 8

`endif

// File: tcpm_pkg.sv
// Purpose: Shared types of the port controller.
// Assumes: tcpm_defs.svh holds the address and fault widths; the 32-bit data width is set here.
// Notes: Types only.
`include "tcpm_defs.svh"
package tcpm_pkg;
	typedef logic [`TCPM_AW-1:0] tcpm_addr_t;
	typedef logic [31:0] tcpm_data_t;
	typedef logic [`TCPM_NFAULT-1:0] tcpm_fault_t;
	typedef enum logic [1:0] {TCPM_OFF, TCPM_WAIT_RD, TCPM_RUN} tcpm_conv_e;
endpackage

// File: tcpm_flags_if.sv
// Purpose: Carrier between the top and the fault flag unit.
// Assumes: One clock domain.
// Notes: Modport ctl for the top, flg for the flag unit.
`timescale 1ns/1ps
`default_nettype none
interface tcpm_flags_if;
	tcpm_pkg::tcpm_fault_t fault_cond;
	tcpm_pkg::tcpm_fault_t mask;
	logic auto_clear;
	logic read_clear;
	tcpm_pkg::tcpm_fault_t flags;
	logic irq_any;
	logic new_flag;
	modport ctl(output fault_cond, output mask, output auto_clear, output read_clear,
		input flags, input irq_any, input new_flag);
	modport flg(input fault_cond, input mask, input auto_clear, input read_clear,
		output flags, output irq_any, output new_flag);
endinterface
`default_nettype wire

// File: tcpm_flags.sv
// Purpose: Sticky fault flags with read-clear, auto-clear and pin mask.
// Assumes: Fault conditions are synchronous levels.
// Notes: A fault present during the clearing read keeps its flag set.
`timescale 1ns/1ps
`default_nettype none
module tcpm_flags (
	input wire logic clock_i,
	input wire logic resetn_i,
	tcpm_flags_if.flg fl
);
	import tcpm_pkg::*;

	typedef struct packed {
		tcpm_fault_t flags;
	} tcpm_fstate_s;

	tcpm_fstate_s st_reg;
	tcpm_fstate_s st_next;

	// Set wins over both clears so no event is lost.
	always_comb begin
		st_next = st_reg;
		if (fl.read_clear) begin
			st_next.flags = '0;
		end
		if (fl.auto_clear) begin
			st_next.flags = st_next.flags & fl.fault_cond;
		end
		st_next.flags = st_next.flags | fl.fault_cond;
	end

	// State register.
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign fl.flags = st_reg.flags;
	assign fl.irq_any = |(st_reg.flags & fl.mask);
	assign fl.new_flag = |(fl.fault_cond & ~st_reg.flags);

	a_flag_keep: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(st_reg.flags[0] && !fl.read_clear && !fl.auto_clear) |=> st_reg.flags[0])
		else $error("flag dropped without read");
	a_read_clear: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(fl.read_clear && fl.fault_cond == '0) |=> st_reg.flags == '0)
		else $error("read did not clear flags");
	a_event_kept: assert property (@(posedge clock_i) disable iff (!resetn_i)
		fl.fault_cond[0] |=> st_reg.flags[0])
		else $error("fault event lost");
	a_auto_drop: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(fl.auto_clear && !fl.fault_cond[1]) |=> !st_reg.flags[1])
		else $error("auto clear failed");
	c_auto_clear: cover property (@(posedge clock_i) disable iff (!resetn_i)
		fl.auto_clear ##1 st_reg.flags[0] ##1 !st_reg.flags[0]);
endmodule
`default_nettype wire

// File: tcpm_top.sv
// Purpose: Type-C port mode, converter gating, orientation and fault flag control.
// Assumes: 200 MHz clock_i; pins pass a three-stage synchroniser.
// Notes: Registers reached over a plain strobe port, read data one cycle later.
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "tcpm_defs.svh"
module tcpm_top #(
	parameter int NFAULT = `TCPM_NFAULT
) (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire tcpm_pkg::tcpm_addr_t addr_i,
	input wire tcpm_pkg::tcpm_data_t wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output tcpm_pkg::tcpm_data_t rdata_o,
	input wire logic charge_mode_strap_i,
	input wire logic device_enable_in_i,
	input wire logic converter_enable_in_i,
	input wire logic rd_cc1_i,
	input wire logic rd_cc2_i,
	input wire logic sync_pin_i,
	input wire logic sync_clk_i,
	output logic sync_pin_o,
	output logic sync_pin_oe_o,
	input wire tcpm_pkg::tcpm_fault_t fault_cond_i,
	output logic converter_on_o,
	output logic forced_pwm_o,
	output logic cable_orientation_out_o,
	output logic cable_orientation_out_oe_o,
	output logic fault_irq_n_o,
	output logic fault_irq_n_oe_o,
	output logic irq_o
);
	import tcpm_pkg::*;

	localparam int NPIN = 6;

	typedef struct packed {
		logic [NPIN-1:0] s1;
		logic [NPIN-1:0] s2;
		logic [NPIN-1:0] s3;
		logic [NPIN-1:0] pin;
		logic started;
		logic typec_detect_disable;
		logic flag_auto_clear;
		logic sync_as_input;
		logic [1:0] charge_detect_mode;
		tcpm_fault_t fmask;
		tcpm_conv_e conv;
		logic orient_cc2;
		logic attached;
		logic pwm;
		logic [`TCPM_EV_N-1:0] irq_stat;
		logic [`TCPM_EV_N-1:0] irq_mask;
		tcpm_data_t rdata;
	} tcpm_state_s;

	tcpm_state_s st_reg;
	tcpm_state_s st_next;
	tcpm_flags_if fl();

	// Pin positions inside the synchroniser vector.
	localparam int P_STRAP = 0;
	localparam int P_DEN = 1;
	localparam int P_CEN = 2;
	localparam int P_CC1 = 3;
	localparam int P_CC2 = 4;
	localparam int P_SYNC = 5;

	// Register hit test, used for each decode.
	function automatic logic hit(input tcpm_addr_t a, input tcpm_addr_t off);
		hit = (a == off);
	endfunction

	tcpm_flags u_flags (
		.clock_i(clock_i),
		.resetn_i(resetn_i),
		.fl(fl.flg)
	);

	assign fl.fault_cond = fault_cond_i;
	assign fl.mask = st_reg.fmask;
	assign fl.auto_clear = st_reg.flag_auto_clear;
	assign fl.read_clear = rd_i && hit(addr_i, `TCPM_ADDR_FLAGS);

	logic [NPIN-1:0] raw;
	logic [`TCPM_EV_N-1:0] ev;
	logic en_ok;
	logic rd_seen;
	assign raw = {sync_pin_i, rd_cc2_i, rd_cc1_i, converter_enable_in_i,
		device_enable_in_i, charge_mode_strap_i};

	// Next-state logic: synchronisers, control, converter sequencing and bus.
	always_comb begin
		st_next = st_reg;
		// Stage one is read only by stage two.
		st_next.s1 = raw;
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
		for (int i = 0; i < NPIN; i++) begin
			if (st_reg.s2[i] == st_reg.s3[i]) begin
				st_next.pin[i] = st_reg.s3[i];
			end
		end
		// Strap is caught at the first edge after reset, since s2 and s3 both still hold their reset zeros.
		if (!st_reg.started && st_reg.s2 == st_reg.s3) begin
			st_next.started = 1'b1;
			if (!st_reg.s3[P_STRAP]) begin
				st_next.charge_detect_mode = `TCPM_CD_SDP;
			end
		end
		// Register writes.
		if (wr_i) begin
			if (hit(addr_i, `TCPM_ADDR_CTRL)) begin
				st_next.typec_detect_disable = wdata_i[`TCPM_CTRL_TCDIS];
				st_next.flag_auto_clear = wdata_i[`TCPM_CTRL_ACLR];
				st_next.sync_as_input = wdata_i[`TCPM_CTRL_SYNCIN];
				st_next.charge_detect_mode = wdata_i[`TCPM_CTRL_CD_HI:`TCPM_CTRL_CD_LO];
			end
			if (hit(addr_i, `TCPM_ADDR_MASK)) begin
				st_next.fmask = wdata_i[NFAULT-1:0];
			end
			if (hit(addr_i, `TCPM_ADDR_IRQ_STAT)) begin
				st_next.irq_stat = st_reg.irq_stat & ~wdata_i[`TCPM_EV_N-1:0];
			end
			if (hit(addr_i, `TCPM_ADDR_IRQ_MASK)) begin
				st_next.irq_mask = wdata_i[`TCPM_EV_N-1:0];
			end
		end
		// A high strap overrides whatever software wrote.
		if (st_reg.started && st_reg.pin[P_STRAP]) begin
			st_next.charge_detect_mode = `TCPM_CD_AUTO_CDP;
		end
		// Converter sequencing.
		en_ok = st_reg.pin[P_DEN] && st_reg.pin[P_CEN];
		rd_seen = st_reg.pin[P_CC1] || st_reg.pin[P_CC2];
		ev = '0;
		case (st_reg.conv)
			TCPM_OFF: begin
				if (en_ok) begin
					st_next.conv = st_reg.typec_detect_disable ? TCPM_RUN : TCPM_WAIT_RD;
				end
			end
			TCPM_WAIT_RD: begin
				if (!en_ok) begin
					st_next.conv = TCPM_OFF;
				end else if (st_reg.typec_detect_disable || rd_seen) begin
					st_next.conv = TCPM_RUN;
				end
			end
			TCPM_RUN: begin
				if (!en_ok) begin
					st_next.conv = TCPM_OFF;
				end else if (!st_reg.typec_detect_disable && !rd_seen) begin
					st_next.conv = TCPM_WAIT_RD;
				end
			end
			default: begin
				st_next.conv = TCPM_OFF;
			end
		endcase
		// Attach and orientation track the termination; CC1 wins if both show one.
		st_next.attached = !st_reg.typec_detect_disable && rd_seen;
		if (!st_reg.typec_detect_disable && st_reg.pin[P_CC1]) begin
			st_next.orient_cc2 = 1'b0;
		end else if (!st_reg.typec_detect_disable && st_reg.pin[P_CC2]) begin
			st_next.orient_cc2 = 1'b1;
		end
		// Light-load mode from the sync pin, only in legacy mode.
		if (st_reg.typec_detect_disable && st_reg.sync_as_input) begin
			st_next.pwm = st_reg.pin[P_SYNC];
		end else begin
			st_next.pwm = 1'b0;
		end
		// Events: set beats the write-one clear.
		ev[`TCPM_EV_FLAG] = fl.new_flag;
		ev[`TCPM_EV_ATTACH] = st_next.attached && !st_reg.attached;
		ev[`TCPM_EV_DETACH] = !st_next.attached && st_reg.attached;
		st_next.irq_stat = st_next.irq_stat | ev;
		// Read data stands in the cycle after the strobe only.
		st_next.rdata = '0;
		if (rd_i) begin
			if (hit(addr_i, `TCPM_ADDR_CTRL)) begin
				st_next.rdata[`TCPM_CTRL_TCDIS] = st_reg.typec_detect_disable;
				st_next.rdata[`TCPM_CTRL_ACLR] = st_reg.flag_auto_clear;
				st_next.rdata[`TCPM_CTRL_SYNCIN] = st_reg.sync_as_input;
				st_next.rdata[`TCPM_CTRL_CD_HI:`TCPM_CTRL_CD_LO] = st_reg.charge_detect_mode;
			end
			if (hit(addr_i, `TCPM_ADDR_STATUS)) begin
				st_next.rdata[`TCPM_ST_CONV] = (st_reg.conv == TCPM_RUN);
				st_next.rdata[`TCPM_ST_PWM] = st_reg.pwm;
				st_next.rdata[`TCPM_ST_ORIENT] = st_reg.orient_cc2;
				st_next.rdata[`TCPM_ST_ATT] = st_reg.attached;
				st_next.rdata[`TCPM_ST_SYNCOE] = !st_reg.sync_as_input;
			end
			if (hit(addr_i, `TCPM_ADDR_FLAGS)) begin
				st_next.rdata[NFAULT-1:0] = fl.flags;
			end
			if (hit(addr_i, `TCPM_ADDR_MASK)) begin
				st_next.rdata[NFAULT-1:0] = st_reg.fmask;
			end
			if (hit(addr_i, `TCPM_ADDR_IRQ_STAT)) begin
				st_next.rdata[`TCPM_EV_N-1:0] = st_reg.irq_stat;
			end
			if (hit(addr_i, `TCPM_ADDR_IRQ_MASK)) begin
				st_next.rdata[`TCPM_EV_N-1:0] = st_reg.irq_mask;
			end
		end
	end

	// State register; the charge mode waits for the strap capture after release.
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs. Sync drives out unless software turns it to an input.
	assign rdata_o = st_reg.rdata;
	assign sync_pin_o = sync_clk_i;
	assign sync_pin_oe_o = !st_reg.sync_as_input;
	assign converter_on_o = (st_reg.conv == TCPM_RUN);
	assign forced_pwm_o = st_reg.pwm;
	// Open drain: released for CC1, pulled low for CC2.
	assign cable_orientation_out_o = 1'b0;
	assign cable_orientation_out_oe_o = st_reg.orient_cc2;
	assign fault_irq_n_o = 1'b0;
	assign fault_irq_n_oe_o = fl.irq_any;
	assign irq_o = |(st_reg.irq_stat & st_reg.irq_mask);

	// Control-path checks; each one names the rule that it guards.
	a_conv_needs_en: assert property (@(posedge clock_i) disable iff (!resetn_i)
		converter_on_o |-> (st_reg.pin[P_DEN] && st_reg.pin[P_CEN]) || $past(en_ok))
		else $error("converter on without both enables");
	a_enables_off: assert property (@(posedge clock_i) disable iff (!resetn_i)
		!en_ok |=> !converter_on_o)
		else $error("converter left on after an enable dropped");
	a_conv_waits_rd: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(st_reg.conv == TCPM_WAIT_RD && !rd_seen && !st_reg.typec_detect_disable)
		|=> !converter_on_o)
		else $error("converter on without termination");
	a_strap_sdp: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(!st_reg.started && !wr_i) |=> st_reg.charge_detect_mode == `TCPM_CD_SDP)
		else $error("startup mode not standard");
	a_strap_force: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(st_reg.started && st_reg.pin[P_STRAP])
		|=> st_reg.charge_detect_mode == `TCPM_CD_AUTO_CDP)
		else $error("strap did not force mode");
	a_detect_off: assert property (@(posedge clock_i) disable iff (!resetn_i)
		st_reg.typec_detect_disable |=> !st_reg.attached)
		else $error("attach seen while detection is off");
	// Direction of the sync pin follows a control write one cycle later.
	a_sync_dir: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(wr_i && addr_i == `TCPM_ADDR_CTRL)
		|=> sync_pin_oe_o == !$past(wdata_i[`TCPM_CTRL_SYNCIN]))
		else $error("sync pin direction wrong");
	a_skip_mode: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(st_reg.typec_detect_disable && st_reg.sync_as_input && !st_reg.pin[P_SYNC])
		|=> !forced_pwm_o)
		else $error("forced PWM with sync input low");
	a_pwm_mode: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(st_reg.typec_detect_disable && st_reg.sync_as_input)
		|=> forced_pwm_o == $past(st_reg.pin[P_SYNC]))
		else $error("sync mode wrong");
	a_orient_cc2: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(!st_reg.typec_detect_disable && !st_reg.pin[P_CC1] && st_reg.pin[P_CC2])
		|=> cable_orientation_out_oe_o)
		else $error("orientation not low for CC2");
	a_orient_cc1: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(!st_reg.typec_detect_disable && st_reg.pin[P_CC1])
		|=> !cable_orientation_out_oe_o)
		else $error("orientation not released for CC1");
	// The pin must follow a fault that meets an open mask, one cycle later.
	a_irq_pin: assert property (@(posedge clock_i) disable iff (!resetn_i)
		((fault_cond_i & st_reg.fmask) != '0 && !wr_i) |=> fault_irq_n_oe_o)
		else $error("interrupt pin not asserted");
	a_attach_event: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(!st_reg.attached && !st_reg.typec_detect_disable && rd_seen)
		|=> st_reg.irq_stat[`TCPM_EV_ATTACH])
		else $error("attach event not recorded");
	// Read data stands one cycle, so any idle cycle must read as zero.
	a_rdata_idle: assert property (@(posedge clock_i) disable iff (!resetn_i)
		!rd_i |=> rdata_o == '0)
		else $error("read data not zero when idle");
	c_attach: cover property (@(posedge clock_i) disable iff (!resetn_i)
		st_reg.conv == TCPM_WAIT_RD ##[1:20] converter_on_o);
	c_legacy_pwm: cover property (@(posedge clock_i) disable iff (!resetn_i) forced_pwm_o);
	c_irq: cover property (@(posedge clock_i) disable iff (!resetn_i) irq_o);
	c_orient_cc2: cover property (@(posedge clock_i) disable iff (!resetn_i)
		converter_on_o && cable_orientation_out_oe_o);
endmodule
`default_nettype wire

// File: tcpm_far_model.sv
// Purpose: Far side of the port: the attached sink terminations and the sync line.
// Assumes: The bench picks which CC line carries Rd and what drives the sync line.
// Notes: The sync line has a pull-down, so it reads low while nobody drives it.
`timescale 1ns/1ps
`default_nettype none
module tcpm_far_model (
	input wire logic [1:0] attach_sel_i,
	input wire logic drive_sync_i,
	input wire logic sync_level_i,
	input wire logic dev_sync_i,
	input wire logic dev_sync_oe_i,
	output logic rd_cc1_o,
	output logic rd_cc2_o,
	output logic sync_wire_o
);
	// Code 1 puts Rd on CC1 and code 2 on CC2; any other code leaves both lines open.
	assign rd_cc1_o = (attach_sel_i == 2'd1);
	assign rd_cc2_o = (attach_sel_i == 2'd2);
	// The device wins while it drives; otherwise our driver, otherwise the pull-down.
	assign sync_wire_o = dev_sync_oe_i ? dev_sync_i : (drive_sync_i & sync_level_i);
endmodule
`default_nettype wire

// File: typec_port_mode_and_fault_flags_tb_top.sv
// Purpose: Self-checking bench for the port mode, converter gating and fault flags.
// Assumes: Pin inputs reach the logic about five cycles after they change.
// Notes: Pin checks wait eight cycles so that the synchroniser has settled.
`timescale 1ns/1ps
`default_nettype none
`include "tcpm_defs.svh"
module typec_port_mode_and_fault_flags_tb_top;
	import tcpm_pkg::*;
	logic clock_i, resetn_i, wr_i, rd_i, strap, den, cen, drv_sync, sync_lvl, sync_clk;
	logic rd1, rd2, sync_w, sync_o, sync_oe, conv, pwm, ori, ori_oe, firq, firq_oe, irq;
	logic [1:0] attach;
	tcpm_addr_t addr_i;
	tcpm_data_t wdata_i, rdata_o, rv;
	tcpm_fault_t fault;
	int failures, num_checks;

	tcpm_top DUT (.clock_i(clock_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .charge_mode_strap_i(strap),
		.device_enable_in_i(den), .converter_enable_in_i(cen), .rd_cc1_i(rd1), .rd_cc2_i(rd2),
		.sync_pin_i(sync_w), .sync_clk_i(sync_clk), .sync_pin_o(sync_o), .sync_pin_oe_o(sync_oe),
		.fault_cond_i(fault), .converter_on_o(conv), .forced_pwm_o(pwm),
		.cable_orientation_out_o(ori), .cable_orientation_out_oe_o(ori_oe),
		.fault_irq_n_o(firq), .fault_irq_n_oe_o(firq_oe), .irq_o(irq));
	tcpm_far_model far (.attach_sel_i(attach), .drive_sync_i(drv_sync), .sync_level_i(sync_lvl),
		.dev_sync_i(sync_o), .dev_sync_oe_i(sync_oe), .rd_cc1_o(rd1), .rd_cc2_o(rd2),
		.sync_wire_o(sync_w));

	// Free-running 200 MHz clock.
	initial begin
		clock_i = 1'b0;
		forever #2.5 clock_i = ~clock_i;
	end

	// Lets n edges pass, then steps off the edge so that outputs have settled.
	task automatic step(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Each bus task lowers its strobe at an edge and the next waits one more edge.
	task automatic wr(input tcpm_addr_t a, input tcpm_data_t d);
		@(posedge clock_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clock_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input tcpm_addr_t a, output tcpm_data_t d);
		@(posedge clock_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clock_i);
		rd_i <= 1'b0;
		#1;
		d = rdata_o;
	endtask
	task automatic pulse_fault(input tcpm_fault_t f);
		@(posedge clock_i);
		fault <= f;
		@(posedge clock_i);
		fault <= 8'h00;
		step(4);
	endtask

	task automatic t_startup();
		step(1);
		chk("sync_oe", sync_oe, 1);
		sync_clk <= 1'b1;
		step(1);
		chk("sync_out", sync_o, 1);
		sync_clk <= 1'b0;
		step(8);
		rd(`TCPM_ADDR_CTRL, rv);
		chk("mode", rv[5:4], `TCPM_CD_SDP);
	endtask
	task automatic t_strap();
		strap <= 1'b1;
		step(8);
		wr(`TCPM_ADDR_CTRL, 32'h0000_0010);
		step(2);
		rd(`TCPM_ADDR_CTRL, rv);
		chk("mode", rv[5:4], `TCPM_CD_AUTO_CDP);
		strap <= 1'b0;
	endtask
	task automatic t_gating();
		den <= 1'b1;
		cen <= 1'b1;
		step(8);
		chk("conv", conv, 0);
		attach <= 2'd1;
		step(8);
		chk("conv", conv, 1);
		chk("orient_oe", ori_oe, 0);
		rd(`TCPM_ADDR_STATUS, rv);
		chk("status", rv, 32'h0000_0019);
		attach <= 2'd2;
		step(8);
		chk("orient_oe", ori_oe, 1);
		chk("orient_o", ori, 0);
		cen <= 1'b0;
		step(8);
		chk("conv", conv, 0);
		cen <= 1'b1;
		den <= 1'b0;
		step(8);
		chk("conv", conv, 0);
		den <= 1'b1;
		attach <= 2'd0;
		step(8);
		chk("conv", conv, 0);
	endtask
	task automatic t_legacy();
		wr(`TCPM_ADDR_CTRL, 32'h0000_0005);
		drv_sync <= 1'b1;
		sync_lvl <= 1'b0;
		step(8);
		chk("sync_oe", sync_oe, 0);
		chk("conv", conv, 1);
		chk("pwm", pwm, 0);
		sync_lvl <= 1'b1;
		step(8);
		chk("pwm", pwm, 1);
		sync_lvl <= 1'b0;
		step(8);
		chk("pwm", pwm, 0);
		wr(`TCPM_ADDR_CTRL, 32'h0000_0000);
		drv_sync <= 1'b0;
		step(8);
		chk("sync_oe", sync_oe, 1);
	endtask
	task automatic t_flags();
		wr(`TCPM_ADDR_MASK, 32'h0000_0001);
		wr(`TCPM_ADDR_IRQ_MASK, 32'h0000_0000);
		wr(`TCPM_ADDR_IRQ_STAT, 32'h0000_0007);
		pulse_fault(8'h01);
		chk("fault_pin", firq_oe, 1);
		chk("fault_o", firq, 0);
		chk("irq", irq, 0);
		wr(`TCPM_ADDR_IRQ_MASK, 32'h0000_0001);
		step(2);
		chk("irq", irq, 1);
		wr(`TCPM_ADDR_IRQ_STAT, 32'h0000_0001);
		step(2);
		chk("irq", irq, 0);
		step(4);
		chk("fault_pin", firq_oe, 1);
		rd(`TCPM_ADDR_FLAGS, rv);
		chk("flags", rv, 32'h0000_0001);
		step(2);
		chk("fault_pin", firq_oe, 0);
		pulse_fault(8'h02);
		chk("fault_pin", firq_oe, 0);
		rd(`TCPM_ADDR_FLAGS, rv);
		chk("flags", rv, 32'h0000_0002);
		// The fault is still present while the clearing read is taken.
		@(posedge clock_i);
		fault <= 8'h04;
		step(4);
		rd(`TCPM_ADDR_FLAGS, rv);
		chk("flags", rv, 32'h0000_0004);
		fault <= 8'h00;
		step(2);
		rd(`TCPM_ADDR_FLAGS, rv);
		chk("flags", rv, 32'h0000_0004);
		rd(`TCPM_ADDR_FLAGS, rv);
		chk("flags", rv, 32'h0000_0000);
		wr(`TCPM_ADDR_CTRL, 32'h0000_0002);
		@(posedge clock_i);
		fault <= 8'h01;
		step(4);
		chk("fault_pin", firq_oe, 1);
		fault <= 8'h00;
		step(4);
		chk("fault_pin", firq_oe, 0);
		rd(`TCPM_ADDR_FLAGS, rv);
		chk("flags", rv, 32'h0000_0000);
		rd(8'h40, rv);
		chk("unmapped", rv, 32'h0000_0000);
	endtask

	// Prints the verdict once and ends the run.
	task automatic summarize();
		if (failures == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Main sequence: every input gets a value at time zero, reset is held two cycles.
	initial begin
		{resetn_i, wr_i, rd_i, strap, den, cen, drv_sync, sync_lvl, sync_clk} = '0;
		attach = 2'd0;
		addr_i = '0;
		wdata_i = '0;
		fault = '0;
		repeat (2) @(posedge clock_i);
		resetn_i <= 1'b1;
		t_startup();
		t_strap();
		t_gating();
		t_legacy();
		t_flags();
		summarize();
	end

	// The tests need well under two thousand cycles; a hang is cut off far beyond that.
	initial begin
		#100us;
		failures++;
		summarize();
	end
endmodule
`default_nettype wire
